// ===== shared/rtc_gate_pkg.sv
// Purpose: Shared constants and types for the RTC clock gate and select block.
// Assumes: 8-bit registers on a byte-addressed 20-bit register port.
// Notes:   Addresses, field positions, masks and types of the block follow.
package rtc_gate_pkg;

    // Register port address width
    localparam int ADDR_W = 20;

    // Register addresses on the register port
    localparam logic [ADDR_W-1:0] ENABLE_ADDR  = 20'hF007A; // peripheral_enable_1
    localparam logic [ADDR_W-1:0] MODE_ADDR    = 20'hF00F3; // subclock_supply_mode_ctrl
    localparam logic [ADDR_W-1:0] RETSTAT_ADDR = 20'hF00F9; // retention_reset_status
    localparam logic [ADDR_W-1:0] CTRL0_ADDR   = 20'hFFF9D; // rtc_control_0
    localparam logic [ADDR_W-1:0] CTRL1_ADDR   = 20'hFFF9E; // rtc_control_1
    localparam logic [ADDR_W-1:0] CAL_FIRST    = 20'hFFF92; // First counter/alarm register
    localparam logic [ADDR_W-1:0] CAL_LAST     = 20'hFFF9C; // Last counter/alarm register
    localparam logic [ADDR_W-1:0] CORR_ADDR    = 20'hF0320; // clock_error_correction

    // Field positions
    localparam logic [2:0] RTC_EN_BIT = 3'h7; // rtc_register_clock_enable
    localparam logic [2:0] GATE_BIT   = 3'h7; // low_power_subclock_gate
    localparam logic [2:0] SEL_BIT    = 3'h4; // count_clock_select

    // Implemented bits and reset values
    localparam logic [7:0] ENABLE_MASK = 8'h80;
    localparam logic [7:0] MODE_MASK   = 8'h90;
    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Nominal clock rates and the interval scale in Q8.8
    localparam int SUB_FREQ_HZ = 32768;  // subsystem_clock_freq
    localparam int IL_FREQ_HZ  = 15000;  // low_speed_osc_freq
    localparam logic [15:0] SCALE_ONE = 16'h0100;
    localparam logic [15:0] SCALE_IL  = 16'((SUB_FREQ_HZ * 256) / IL_FREQ_HZ);

    // One request on the register port
    typedef struct packed {
        logic              wr;      // Write strobe
        logic              rd;      // Read strobe
        logic              bit_op;  // Write is a single-bit manipulation
        logic [2:0]        bit_sel; // Bit touched by a single-bit write
        logic [ADDR_W-1:0] addr;    // Byte address
        logic [7:0]        wdata;   // Byte data, bit value in wdata[0]
    } bus_req_t;

    // Write passed on to the RTC register interface
    typedef struct packed {
        logic              wr;
        logic              bit_op;
        logic [2:0]        bit_sel;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } rtc_fwd_t;

    // Whole state of the control module
    typedef struct packed {
        logic [7:0]  pen;      // peripheral_enable_1
        logic [7:0]  mode;     // subclock_supply_mode_ctrl
        logic [7:0]  rdata;    // Read data for the cycle after a read
        logic        clk_en;   // RTC interface clock enable
        logic        sub_en;   // Peripheral subclock enable
        logic        sel;      // Count clock select
        logic        cal_en;   // Calendar counters usable
        logic [15:0] scale;    // Constant-period scale
    } ctrl_state_t;

    // Whole state of the write gate
    typedef struct packed {
        rtc_fwd_t fwd;       // Forwarded write
        logic     blocked;   // Write dropped by the gate
    } gate_state_t;

endpackage : rtc_gate_pkg

// ===== rtl/rtc_write_gate.sv
// Purpose: Passes register writes to the RTC register interface.
// Assumes: Writes are one-cycle strobes on the block clock.
// Notes:   Outputs are registered, one cycle behind the request.
`timescale 1ns/1ps
module rtc_write_gate #(
    parameter logic [19:0] FIRST_ADDR = rtc_gate_pkg::CAL_FIRST,
    parameter logic [19:0] LAST_ADDR  = rtc_gate_pkg::CAL_LAST
) (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  nrst_i,
    // Request and enable
    input  wire rtc_gate_pkg::bus_req_t req_i,
    input  wire logic                  enable_i,
    // Forwarded write
    output rtc_gate_pkg::rtc_fwd_t      fwd_o,
    output logic                       blocked_o
);
    import rtc_gate_pkg::*;

    gate_state_t r;       // Registered state
    gate_state_t next_r;  // Next state
    logic        gated;   // Address belongs to the gated set
    logic        exempt;  // Address always reachable

    // Address decode of the gated and the exempt sets
    always_comb begin
        gated  = (req_i.addr >= FIRST_ADDR && req_i.addr <= LAST_ADDR) ||
                 req_i.addr == CTRL0_ADDR || req_i.addr == CTRL1_ADDR ||
                 req_i.addr == CORR_ADDR;
        exempt = req_i.addr == RETSTAT_ADDR;
    end

    // Next forwarded write
    always_comb begin
        next_r             = r;
        next_r.fwd.wr      = req_i.wr && (exempt || (gated && enable_i));
        next_r.fwd.bit_op  = req_i.bit_op;
        next_r.fwd.bit_sel = req_i.bit_sel;
        next_r.fwd.addr    = req_i.addr;
        next_r.fwd.wdata   = req_i.wdata;
        next_r.blocked     = req_i.wr && gated && !enable_i;
    end

    // State register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign fwd_o     = r.fwd;
    assign blocked_o = r.blocked;

    // Gated write with the clock off never reaches the interface
    property p_block;
        @(posedge clk_i) disable iff (!nrst_i)
        req_i.wr && gated && !enable_i |=> !fwd_o.wr && blocked_o;
    endproperty
    a_block: assert property (p_block) else $error("gated write passed");

    // Retention status writes pass whatever the enable
    property p_exempt;
        @(posedge clk_i) disable iff (!nrst_i)
        req_i.wr && exempt |=> fwd_o.wr && fwd_o.addr == $past(req_i.addr);
    endproperty
    a_exempt: assert property (p_exempt) else $error("exempt write lost");

endmodule : rtc_write_gate

// ===== rtl/rtc_clock_gate_select.sv
// Purpose: Clock gating and count clock selection ahead of the RTC and timer.
// Assumes: Standby mode inputs come from logic on the same clock.
// Notes:   Read data stand only in the cycle after the read strobe.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module rtc_clock_gate_select (
    // Clock and reset
    input  wire logic                   CLK_I,
    input  wire logic                   NRST_I,
    // Register port
    input  wire rtc_gate_pkg::bus_req_t BUS_I,
    output logic [7:0]                  RDATA_O,
    // Standby state of the CPU
    input  wire logic                   STOP_MODE_I,
    input  wire logic                   HALT_MODE_I,
    input  wire logic                   CPU_ON_SUBCLK_I,
    // RTC register interface
    output logic                        RTC_REG_CLK_EN_O,
    output rtc_gate_pkg::rtc_fwd_t      RTC_FWD_O,
    output logic                        RTC_WR_BLOCKED_O,
    // Clock supply and selection
    output logic                        PERIPH_SUBCLK_EN_O,
    output logic                        COUNT_CLK_SEL_O,
    output logic                        LOW_SPEED_OSC_RUN_O,
    output logic                        CALENDAR_EN_O,
    output logic                        ONE_HZ_EN_O,
    output logic [15:0]                 PERIOD_SCALE_O
);
    import rtc_gate_pkg::*;

    ctrl_state_t r;          // Registered state
    ctrl_state_t next_r;     // Next state
    logic        enable_hit; // Request addresses the enable register
    logic        mode_hit;   // Request addresses the mode register
    logic        standby;    // CPU in a state where the gate bit acts

    // Applies a byte or single-bit write to a register image
    function automatic logic [7:0] apply_write(
        input logic [7:0] old,
        input bus_req_t   req,
        input logic [7:0] mask,
        input logic       bit_ok
    );
        logic [7:0] val;
        val = old;
        if (req.bit_op) begin
            // Single-bit write touches one bit only
            if (bit_ok) begin
                val[req.bit_sel] = req.wdata[0];
            end
        end else begin
            // Byte write replaces the whole image
            val = req.wdata;
        end
        return val & mask;
    endfunction : apply_write

    // Address decode and standby condition
    always_comb begin
        enable_hit = BUS_I.addr == ENABLE_ADDR;
        mode_hit   = BUS_I.addr == MODE_ADDR;
        standby  = STOP_MODE_I || (HALT_MODE_I && CPU_ON_SUBCLK_I);
    end

    // Next state of registers and clock controls
    always_comb begin
        next_r = r;
        // Enable register takes bit and byte writes
        if (BUS_I.wr && enable_hit) begin
            next_r.pen = apply_write(r.pen, BUS_I, ENABLE_MASK, 1'b1);
        end
        // Mode register ignores bit writes and unused bits
        if (BUS_I.wr && mode_hit) begin
            next_r.mode = apply_write(r.mode, BUS_I, MODE_MASK, 1'b0);
        end
        // Read data for the next cycle only
        next_r.rdata = READ_ZERO;
        if (BUS_I.rd) begin
            if (enable_hit) begin
                next_r.rdata = r.pen;
            end else if (mode_hit) begin
                next_r.rdata = r.mode;
            end
        end
        // Interface clock follows the enable bit
        next_r.clk_en = next_r.pen[RTC_EN_BIT];
        // Peripheral subclock stops only with gate bit in standby
        next_r.sub_en = !(next_r.mode[GATE_BIT] && standby);
        // Count clock choice and its effects
        next_r.sel    = next_r.mode[SEL_BIT];
        next_r.cal_en = !next_r.mode[SEL_BIT];
        // Period scale is the ratio of nominal rates
        next_r.scale  = next_r.mode[SEL_BIT] ? SCALE_IL : SCALE_ONE;
    end

    // State register; reset clears it but sets sub_en, cal_en and scale to SCALE_ONE
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            r        <= '0;
            r.sub_en <= 1'b1;
            r.cal_en <= 1'b1;
            r.scale  <= SCALE_ONE;
        end else begin
            r <= next_r;
        end
    end

    // Writes to RTC registers other than retention status pass only while clock enabled
    rtc_write_gate #(
        .FIRST_ADDR (CAL_FIRST),
        .LAST_ADDR  (CAL_LAST)
    ) u_gate (
        .clk_i      (CLK_I),
        .nrst_i     (NRST_I),
        .req_i      (BUS_I),
        .enable_i   (r.clk_en),
        .fwd_o      (RTC_FWD_O),
        .blocked_o  (RTC_WR_BLOCKED_O)
    );

    // Outputs straight from the state register
    assign RDATA_O             = r.rdata;
    assign RTC_REG_CLK_EN_O    = r.clk_en;
    assign PERIPH_SUBCLK_EN_O  = r.sub_en;
    assign COUNT_CLK_SEL_O     = r.sel;
    assign LOW_SPEED_OSC_RUN_O = r.sel;
    assign CALENDAR_EN_O       = r.cal_en;
    assign ONE_HZ_EN_O         = r.cal_en;
    assign PERIOD_SCALE_O      = r.scale;

    // Registers hold zero at the first edge after reset
    property p_reset_zero;
        @(posedge CLK_I) disable iff (!NRST_I)
        $rose(NRST_I) |-> r.pen == RESET_VAL && r.mode == RESET_VAL && !RTC_REG_CLK_EN_O;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("not zero after reset");

    // Single-bit write to the enable bit takes effect
    property p_bit_write;
        @(posedge CLK_I) disable iff (!NRST_I)
        BUS_I.wr && enable_hit && BUS_I.bit_op && BUS_I.bit_sel == RTC_EN_BIT
        |=> RTC_REG_CLK_EN_O == $past(BUS_I.wdata[0]);
    endproperty
    a_bit_write: assert property (p_bit_write) else $error("bit write lost");

    // Byte write to the enable register sets or stops the clock
    property p_byte_enable;
        @(posedge CLK_I) disable iff (!NRST_I)
        BUS_I.wr && enable_hit && !BUS_I.bit_op
        |=> RTC_REG_CLK_EN_O == $past(BUS_I.wdata[RTC_EN_BIT]) ##1 $stable(RTC_REG_CLK_EN_O)
            || $past(BUS_I.wr);
    endproperty
    a_byte_enable: assert property (p_byte_enable) else $error("enable not applied");

    // Bit writes leave the mode register untouched
    property p_mode_byte_only;
        @(posedge CLK_I) disable iff (!NRST_I)
        BUS_I.wr && mode_hit && BUS_I.bit_op |=> $stable(r.mode);
    endproperty
    a_mode_byte_only: assert property (p_mode_byte_only) else $error("bit write changed mode");

    // Unused mode bits read back zero
    property p_mode_unused;
        @(posedge CLK_I) disable iff (!NRST_I)
        BUS_I.rd && mode_hit |=> (RDATA_O & ~MODE_MASK) == READ_ZERO;
    endproperty
    a_mode_unused: assert property (p_mode_unused) else $error("unused bit read one");

    // Gate bit in standby stops the peripheral subclock
    property p_gate_stop;
        @(posedge CLK_I) disable iff (!NRST_I)
        r.mode[GATE_BIT] && standby && !BUS_I.wr |=> !PERIPH_SUBCLK_EN_O;
    endproperty
    a_gate_stop: assert property (p_gate_stop) else $error("subclock not stopped");

    // Gate bit clear keeps the subclock running
    property p_gate_keep;
        @(posedge CLK_I) disable iff (!NRST_I)
        !r.mode[GATE_BIT] && !BUS_I.wr |=> PERIPH_SUBCLK_EN_O;
    endproperty
    a_gate_keep: assert property (p_gate_keep) else $error("subclock stopped");

    // Byte write of the select bit moves the count clock
    property p_select;
        @(posedge CLK_I) disable iff (!NRST_I)
        BUS_I.wr && mode_hit && !BUS_I.bit_op
        |=> COUNT_CLK_SEL_O == $past(BUS_I.wdata[SEL_BIT])
            && LOW_SPEED_OSC_RUN_O == COUNT_CLK_SEL_O;
    endproperty
    a_select: assert property (p_select) else $error("select not applied");

    // Low-speed clock disables calendar and 1 Hz output
    property p_calendar_off;
        @(posedge CLK_I) disable iff (!NRST_I)
        COUNT_CLK_SEL_O |-> !CALENDAR_EN_O && !ONE_HZ_EN_O;
    endproperty
    a_calendar_off: assert property (p_calendar_off) else $error("calendar still on");

    // Scale tracks the selected clock
    property p_scale;
        @(posedge CLK_I) disable iff (!NRST_I)
        PERIOD_SCALE_O == (COUNT_CLK_SEL_O ? SCALE_IL : SCALE_ONE);
    endproperty
    a_scale: assert property (p_scale) else $error("wrong period scale");

    // Unmapped read answers zero in the next cycle
    property p_unmapped_read;
        @(posedge CLK_I) disable iff (!NRST_I)
        BUS_I.rd && !enable_hit && !mode_hit |=> RDATA_O == READ_ZERO;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read nonzero");

    // Enable register read returns its image
    property p_read_enable;
        @(posedge CLK_I) disable iff (!NRST_I)
        BUS_I.rd && enable_hit |=> RDATA_O == $past(r.pen);
    endproperty
    a_read_enable: assert property (p_read_enable) else $error("enable read wrong");

    // Mode register read returns its image
    property p_read_mode;
        @(posedge CLK_I) disable iff (!NRST_I)
        BUS_I.rd && mode_hit |=> RDATA_O == $past(r.mode);
    endproperty
    a_read_mode: assert property (p_read_mode) else $error("mode read wrong");

    // Read data fall back to zero without a read
    property p_idle_rdata;
        @(posedge CLK_I) disable iff (!NRST_I)
        !BUS_I.rd |=> RDATA_O == READ_ZERO;
    endproperty
    a_idle_rdata: assert property (p_idle_rdata) else $error("read data held");

    // Reserved enable bits never hold a one
    property p_enable_reserved;
        @(posedge CLK_I) disable iff (!NRST_I)
        (r.pen & ~ENABLE_MASK) == RESET_VAL;
    endproperty
    a_enable_reserved: assert property (p_enable_reserved) else $error("reserved bit set");

    // Unused mode bits never hold a one
    property p_mode_reserved;
        @(posedge CLK_I) disable iff (!NRST_I)
        (r.mode & ~MODE_MASK) == RESET_VAL;
    endproperty
    a_mode_reserved: assert property (p_mode_reserved) else $error("unused mode bit set");

    // Interface clock enable mirrors the stored bit
    property p_clk_follows;
        @(posedge CLK_I) disable iff (!NRST_I)
        RTC_REG_CLK_EN_O == r.pen[RTC_EN_BIT];
    endproperty
    a_clk_follows: assert property (p_clk_follows) else $error("clock enable off bit");

    // Oscillator runs exactly when it is selected
    property p_osc_run;
        @(posedge CLK_I) disable iff (!NRST_I)
        LOW_SPEED_OSC_RUN_O == COUNT_CLK_SEL_O;
    endproperty
    a_osc_run: assert property (p_osc_run) else $error("oscillator run wrong");

    // Subsystem clock keeps calendar and 1 Hz output
    property p_calendar_on;
        @(posedge CLK_I) disable iff (!NRST_I)
        !COUNT_CLK_SEL_O |-> CALENDAR_EN_O && ONE_HZ_EN_O;
    endproperty
    a_calendar_on: assert property (p_calendar_on) else $error("calendar off");

    // Registers hold still without a write
    property p_hold;
        @(posedge CLK_I) disable iff (!NRST_I)
        !BUS_I.wr |=> $stable(r.pen) && $stable(r.mode);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed unwritten");

    // Byte write sets the mode image through its mask
    property p_mode_byte;
        @(posedge CLK_I) disable iff (!NRST_I)
        BUS_I.wr && mode_hit && !BUS_I.bit_op |=> r.mode == ($past(BUS_I.wdata) & MODE_MASK);
    endproperty
    a_mode_byte: assert property (p_mode_byte) else $error("mode byte lost");

    // Outside standby the subclock always runs
    property p_awake_run;
        @(posedge CLK_I) disable iff (!NRST_I)
        !standby && !BUS_I.wr |=> PERIPH_SUBCLK_EN_O;
    endproperty
    a_awake_run: assert property (p_awake_run) else $error("subclock stopped awake");

    // Halt on the main clock is not a gated standby
    property p_halt_main;
        @(posedge CLK_I) disable iff (!NRST_I)
        HALT_MODE_I && !CPU_ON_SUBCLK_I && !STOP_MODE_I && !BUS_I.wr |=> PERIPH_SUBCLK_EN_O;
    endproperty
    a_halt_main: assert property (p_halt_main) else $error("subclock stopped in halt");

    // Bit write to another enable bit leaves the clock alone
    property p_other_bit;
        @(posedge CLK_I) disable iff (!NRST_I)
        BUS_I.wr && enable_hit && BUS_I.bit_op && BUS_I.bit_sel != RTC_EN_BIT
        |=> $stable(RTC_REG_CLK_EN_O);
    endproperty
    a_other_bit: assert property (p_other_bit) else $error("clock moved by bit write");

    // Low-speed selection gives the scaled interval
    property p_scale_il;
        @(posedge CLK_I) disable iff (!NRST_I)
        COUNT_CLK_SEL_O |-> PERIOD_SCALE_O == SCALE_IL;
    endproperty
    a_scale_il: assert property (p_scale_il) else $error("scale not ratio");

endmodule : rtc_clock_gate_select

// ===== dv/rtc_clock_gate_select_tb.sv
// Purpose: Self-checking bench for the RTC clock gate and count clock select block.
// Assumes: Register port answers one cycle after a strobe; outputs registered.
// Notes:   Tests are sequences of bus calls; no partner model is needed.
`timescale 1ns/1ps
module rtc_clock_gate_select_tb;
    import rtc_gate_pkg::*;

    // Clock, reset and standby inputs
    logic                clk;
    logic                nrst;
    logic                stop_mode;
    logic                halt_mode;
    logic                cpu_on_subclk;
    // Register port
    bus_req_t            bus;
    logic [7:0]          rdata;
    // Observed outputs
    logic                reg_clk_en;
    rtc_fwd_t            fwd;
    logic                blocked;
    logic                subclk_en;
    logic                sel;
    logic                osc_run;
    logic                cal_en;
    logic                one_hz_en;
    logic [15:0]         scale;
    // Bookkeeping
    int                  mismatches;
    int                  cmp_count;
    logic [ADDR_W-1:0]   gated [5];

    // Design under test
    rtc_clock_gate_select dut (
        .CLK_I               (clk),
        .NRST_I              (nrst),
        .BUS_I               (bus),
        .RDATA_O             (rdata),
        .STOP_MODE_I         (stop_mode),
        .HALT_MODE_I         (halt_mode),
        .CPU_ON_SUBCLK_I     (cpu_on_subclk),
        .RTC_REG_CLK_EN_O    (reg_clk_en),
        .RTC_FWD_O           (fwd),
        .RTC_WR_BLOCKED_O    (blocked),
        .PERIPH_SUBCLK_EN_O  (subclk_en),
        .COUNT_CLK_SEL_O     (sel),
        .LOW_SPEED_OSC_RUN_O (osc_run),
        .CALENDAR_EN_O       (cal_en),
        .ONE_HZ_EN_O         (one_hz_en),
        .PERIOD_SCALE_O      (scale)
    );

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Compare one value and count it
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One strobe cycle; returns just after the edge that takes it
    task automatic access(input logic w, input logic r, input logic b, input logic [2:0] bs,
                          input logic [ADDR_W-1:0] a, input logic [7:0] d);
        bus_req_t q;
        q = '0;
        q.wr = w;
        q.rd = r;
        q.bit_op = b;
        q.bit_sel = bs;
        q.addr = a;
        q.wdata = d;
        @(posedge clk);
        bus <= q;
        @(posedge clk);
        bus <= '0;
        #1;
    endtask : access

    // Byte read; data stand only in the following cycle
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        access(1'b0, 1'b1, 1'b0, 3'h0, a, 8'h00);
        chk(rdata, exp);
        @(posedge clk);
        #1;
        chk(rdata, 8'h00);
    endtask : rd_chk

    // Write towards the RTC side; expect forward or drop
    task automatic wr_fwd(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic pass);
        access(1'b1, 1'b0, 1'b0, 3'h0, a, d);
        chk(fwd.wr, pass);
        chk(blocked, !pass);
        if (pass) begin
            chk(fwd.addr, a);
            chk(fwd.wdata, d);
        end
    endtask : wr_fwd

    // Apply standby levels and check the peripheral subclock one cycle later
    task automatic standby(input logic s, input logic h, input logic c, input logic exp);
        @(posedge clk);
        stop_mode <= s;
        halt_mode <= h;
        cpu_on_subclk <= c;
        @(posedge clk);
        #1;
        chk(subclk_en, exp);
    endtask : standby

    // Line printed as each test ends
    task automatic end_test(input string name);
        $display("test %s done: %0d compares, %0d mismatches", name, cmp_count, mismatches);
    endtask : end_test

    // Counts, verdict and end of run
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    // Hang guard
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b1, 1'b0);
        conclude();
    end

    // Main sequence
    initial begin
        nrst = 1'b0;
        bus = '0;
        stop_mode = 1'b0;
        halt_mode = 1'b0;
        cpu_on_subclk = 1'b0;
        mismatches = 0;
        cmp_count = 0;
        gated = '{CAL_FIRST, CAL_LAST, CTRL0_ADDR, CTRL1_ADDR, CORR_ADDR};
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        // Reset state of registers and outputs
        rd_chk(ENABLE_ADDR, 8'h00);
        rd_chk(MODE_ADDR, 8'h00);
        chk({reg_clk_en, subclk_en, sel, cal_en, one_hz_en}, 5'b01011);
        chk(scale, 16'h0100);
        end_test("reset");
        // Enable clear: gated writes dropped, ungated ones still work
        foreach (gated[i]) wr_fwd(gated[i], 8'h5A, 1'b0);
        wr_fwd(RETSTAT_ADDR, 8'h01, 1'b1);
        access(1'b1, 1'b0, 1'b0, 3'h0, MODE_ADDR, 8'h80);
        rd_chk(MODE_ADDR, 8'h80);
        access(1'b1, 1'b0, 1'b0, 3'h0, MODE_ADDR, 8'h00);
        end_test("gated");
        // Byte write of enable, reserved bits written zero
        access(1'b1, 1'b0, 1'b0, 3'h0, ENABLE_ADDR, 8'h80);
        rd_chk(ENABLE_ADDR, 8'h80);
        chk(reg_clk_en, 1'b1);
        foreach (gated[i]) wr_fwd(gated[i], gated[i][7:0], 1'b1);
        end_test("enable");
        // Single-bit clear and set of the enable
        access(1'b1, 1'b0, 1'b1, RTC_EN_BIT, ENABLE_ADDR, 8'h00);
        chk(reg_clk_en, 1'b0);
        wr_fwd(CTRL0_ADDR, 8'h80, 1'b0);
        access(1'b1, 1'b0, 1'b1, RTC_EN_BIT, ENABLE_ADDR, 8'h01);
        chk(reg_clk_en, 1'b1);
        rd_chk(ENABLE_ADDR, 8'h80);
        end_test("bitwrite");
        // Count clock select and its side effects; RTC and timer idle here
        access(1'b1, 1'b0, 1'b0, 3'h0, MODE_ADDR, 8'hFF);
        rd_chk(MODE_ADDR, 8'h90);
        chk(sel, 1'b1);
        chk(osc_run, 1'b1);
        chk({cal_en, one_hz_en}, 2'b00);
        chk(scale, 16'h022F);
        access(1'b1, 1'b0, 1'b1, SEL_BIT, MODE_ADDR, 8'h00);
        rd_chk(MODE_ADDR, 8'h90);
        access(1'b1, 1'b0, 1'b0, 3'h0, MODE_ADDR, 8'h80);
        chk({sel, osc_run, cal_en, one_hz_en}, 4'b0011);
        chk(scale, 16'h0100);
        end_test("select");
        // Standby gating with the gate bit set, then clear
        standby(1'b0, 1'b0, 1'b0, 1'b1);
        standby(1'b1, 1'b0, 1'b0, 1'b0);
        standby(1'b0, 1'b1, 1'b1, 1'b0);
        standby(1'b0, 1'b1, 1'b0, 1'b1);
        standby(1'b0, 1'b0, 1'b1, 1'b1);
        access(1'b1, 1'b0, 1'b0, 3'h0, MODE_ADDR, 8'h00);
        standby(1'b1, 1'b0, 1'b0, 1'b1);
        standby(1'b0, 1'b1, 1'b1, 1'b1);
        standby(1'b0, 1'b0, 1'b0, 1'b1);
        end_test("standby");
        // Unmapped read, then a reset in mid-run
        rd_chk(20'h00000, 8'h00);
        access(1'b1, 1'b0, 1'b0, 3'h0, MODE_ADDR, 8'h90);
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        #1;
        chk({reg_clk_en, sel, cal_en, scale}, {3'b001, 16'h0100});
        nrst <= 1'b1;
        rd_chk(ENABLE_ADDR, 8'h00);
        rd_chk(MODE_ADDR, 8'h00);
        end_test("midreset");
        conclude();
    end

endmodule : rtc_clock_gate_select_tb
